// ---- sdc_pkg.sv ----
// shared constants, types and pin encodings for the sdram command decode pair
// assumes a single 250 MHz clock shared by the controller end and the memory end
`default_nettype none
package sdc_pkg;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NBANK = 4;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int COL_W = 12;
  localparam int AP_BIT = 10;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam logic [LANES-1:0] DQM_RST = 4'hF;
  // {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_WR = 3'h4;
  localparam logic [2:0] CODE_RD = 3'h5;
  localparam logic [2:0] CODE_BST = 3'h6;
  localparam logic [2:0] CODE_NOP = 3'h7;

  typedef enum logic [4:0] {
    CMD_NONE, CMD_DESEL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREALL, CMD_WR, CMD_RD, CMD_MRS, CMD_BST,
    CMD_REF, CMD_SREF_ENTER, CMD_SREF_EXIT, CMD_PD_ENTER, CMD_PD_EXIT, CMD_CKS_ENTER, CMD_CKS_EXIT
  } sdc_cmd_t;

  typedef enum logic [1:0] {PW_NORMAL, PW_SELF, PW_PDOWN, PW_SUSP} sdc_pwr_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_DESEL, OP_ACT, OP_PRE, OP_PREALL, OP_WR, OP_RD, OP_MRS, OP_BST, OP_REF
  } sdc_op_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_pins_t;

  typedef struct packed {
    logic cke;
    sdc_op_t op;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic auto_precharge_flag;
    logic [LANES-1:0] dqm;
    logic drive;
    logic [DQ_W-1:0] data;
    logic capture;
  } sdc_word_t;

  function automatic sdc_pins_t op_pins(input sdc_op_t op);
    sdc_pins_t p;
    p.cs_n = 1'b0;
    unique case (op)
      OP_DESEL: {p.cs_n, p.ras_n, p.cas_n, p.we_n} = {1'b1, CODE_NOP};
      OP_ACT: {p.ras_n, p.cas_n, p.we_n} = CODE_ACT;
      OP_PRE, OP_PREALL: {p.ras_n, p.cas_n, p.we_n} = CODE_PRE;
      OP_WR: {p.ras_n, p.cas_n, p.we_n} = CODE_WR;
      OP_RD: {p.ras_n, p.cas_n, p.we_n} = CODE_RD;
      OP_MRS: {p.ras_n, p.cas_n, p.we_n} = CODE_MRS;
      OP_BST: {p.ras_n, p.cas_n, p.we_n} = CODE_BST;
      OP_REF: {p.ras_n, p.cas_n, p.we_n} = CODE_REF;
      default: {p.ras_n, p.cas_n, p.we_n} = CODE_NOP;
    endcase
    return p;
  endfunction

  function automatic logic [NBANK-1:0] bank_onehot(input logic [BA_W-1:0] ba);
    return 4'h1 << ba;
  endfunction

  // a10 is skipped: on column commands it carries the auto precharge request
  function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] a);
    return {a[12:11], a[9:0]};
  endfunction

  // low column bits that wrap inside a burst; full page is held to eight beats
  function automatic logic [2:0] burst_mask(input logic [2:0] bl);
    unique case (bl)
      3'h0: return 3'h0;
      3'h1: return 3'h1;
      3'h2: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- sdc_if.sv ----
// pin bundle between the sdram controller end and the memory end
// both ends drive the shared data bus; the wire level is resolved here from the enables
`default_nettype none
interface sdc_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [sdc_pkg::BA_W-1:0] ba;
  logic [sdc_pkg::ADDR_W-1:0] addr;
  logic [sdc_pkg::LANES-1:0] dqm;
  logic [sdc_pkg::DQ_W-1:0] h_dq_o;
  logic h_dq_oe_n;
  logic [sdc_pkg::DQ_W-1:0] d_dq_o;
  logic [sdc_pkg::LANES-1:0] d_dq_oe_n;
  logic [sdc_pkg::DQ_W-1:0] dq;

  // an undriven lane reads as zero
  always_comb begin
    for (int i = 0; i < sdc_pkg::LANES; i++) begin
      if (!d_dq_oe_n[i]) begin
        dq[i*8 +: 8] = d_dq_o[i*8 +: 8];
      end else if (!h_dq_oe_n) begin
        dq[i*8 +: 8] = h_dq_o[i*8 +: 8];
      end else begin
        dq[i*8 +: 8] = 8'h00;
      end
    end
  end

  modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, h_dq_o, h_dq_oe_n, input dq);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq, output d_dq_o, d_dq_oe_n);
endinterface
`default_nettype wire

// ---- sdc_dev.sv ----
// memory end: decodes the sampled command pins, tracks banks, power state and bursts
// assumes the controller drives the pins synchronously to i_ref_clk; read data arrives from the user same cycle
`default_nettype none
// Functional notes
// RULE1: commands decoded from pins at rising edge
// RULE2: activate opens row in idle selected bank
// RULE3: precharge one bank, or all with a10
// RULE4: write starts burst, a10 requests auto precharge
// RULE5: read starts burst, a10 requests auto precharge
// RULE6: mode set loads address when all idle
// RULE7: no-operation starts nothing new
// RULE8: burst stop ends burst while bank active
// RULE9: chip select high ignores other strobes
// RULE10: refresh with clock enable high both cycles
// RULE11: refresh encoding with enable falling: self refresh
// RULE12: self refresh exits on enable rise, deselect/nop; code also exits on burst stop, as we_n is not checked
// RULE13: enable falling with bank active: clock suspend; code enters power down instead on deselect/nop when no burst runs
// RULE14: enable falling on deselect/nop: power down
// RULE15: enable rising leaves clock suspend, resumes operation
// RULE16: power down exits on enable rise, deselect/nop
// RULE17: clock enable judged from current and previous sample
// RULE18: bank state judged for addressed bank only
// RULE19: each mask bit blocks one byte lane
// RULE20: a10 is auto precharge flag on column commands
// RULE21: bank address selects one of four banks
// RULE22: deselect or nop never breaks running burst
module sdc_dev (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  sdc_if.dev bus,
  input wire logic [sdc_pkg::DQ_W-1:0] i_rd_data,
  output sdc_pkg::sdc_cmd_t o_cmd,
  output sdc_pkg::sdc_pwr_t o_pwr,
  output logic [sdc_pkg::NBANK-1:0] o_bank_active,
  output logic [sdc_pkg::ADDR_W-1:0] o_mode,
  output logic o_refresh,
  output logic o_wr_valid,
  output logic [sdc_pkg::BA_W-1:0] o_wr_bank,
  output logic [sdc_pkg::ADDR_W-1:0] o_wr_row,
  output logic [sdc_pkg::COL_W-1:0] o_wr_col,
  output logic [sdc_pkg::DQ_W-1:0] o_wr_data,
  output logic [sdc_pkg::LANES-1:0] o_wr_be,
  output logic o_rd_req,
  output logic [sdc_pkg::BA_W-1:0] o_rd_bank,
  output logic [sdc_pkg::ADDR_W-1:0] o_rd_row,
  output logic [sdc_pkg::COL_W-1:0] o_rd_col
);
  logic cke_prev_q;
  sdc_pkg::sdc_pwr_t pwr_q;
  logic [sdc_pkg::NBANK-1:0] bank_act_q;
  logic [sdc_pkg::ADDR_W-1:0] row_q [sdc_pkg::NBANK];
  logic [sdc_pkg::ADDR_W-1:0] mode_q;
  sdc_pkg::sdc_cmd_t cmd_q;
  logic refresh_q;
  logic run_q;
  logic [2:0] left_q;
  logic wr_q;
  logic ap_q;
  logic [sdc_pkg::BA_W-1:0] bank_q;
  logic [sdc_pkg::COL_W-1:0] col_q;
  logic wr_valid_q;
  logic [sdc_pkg::BA_W-1:0] wr_bank_q;
  logic [sdc_pkg::ADDR_W-1:0] wr_row_q;
  logic [sdc_pkg::COL_W-1:0] wr_col_q;
  logic [sdc_pkg::DQ_W-1:0] wr_data_q;
  logic [sdc_pkg::LANES-1:0] wr_be_q;
  logic rd_req_q;
  logic [sdc_pkg::BA_W-1:0] rd_bank_q;
  logic [sdc_pkg::ADDR_W-1:0] rd_row_q;
  logic [sdc_pkg::COL_W-1:0] rd_col_q;
  logic [sdc_pkg::LANES-1:0] rd_mask_q;
  logic [sdc_pkg::DQ_W-1:0] dq_o_q;
  logic [sdc_pkg::LANES-1:0] dq_oe_n_q;

  sdc_pkg::sdc_cmd_t cmd;
  logic [2:0] code;
  logic sel_active;
  logic all_idle;
  logic start;
  logic stop;
  logic beat;
  logic last;
  logic ap_eff;
  logic beat_wr;
  logic [sdc_pkg::BA_W-1:0] beat_bank;
  logic [sdc_pkg::COL_W-1:0] beat_col;
  logic [sdc_pkg::COL_W-1:0] col_nx;
  logic [2:0] mask;
  logic [sdc_pkg::NBANK-1:0] act_set;
  logic [sdc_pkg::NBANK-1:0] act_clr;

  assign code = {bus.ras_n, bus.cas_n, bus.we_n};
  assign sel_active = bank_act_q[bus.ba]; // [RULE18] [RULE21]
  assign all_idle = ~|bank_act_q;

  // the enable falling edge is resolved first; a busy burst forces suspend over power down
  always_comb begin
    cmd = sdc_pkg::CMD_NONE;
    unique case (pwr_q)
      sdc_pkg::PW_SELF: begin
        if (!cke_prev_q && bus.cke && (bus.cs_n || (bus.ras_n && bus.cas_n))) begin
          cmd = sdc_pkg::CMD_SREF_EXIT; // [RULE12]
        end
      end
      sdc_pkg::PW_PDOWN: begin
        if (!cke_prev_q && bus.cke && (bus.cs_n || code == sdc_pkg::CODE_NOP)) begin
          cmd = sdc_pkg::CMD_PD_EXIT; // [RULE16]
        end
      end
      sdc_pkg::PW_SUSP: begin
        if (bus.cke) begin
          cmd = sdc_pkg::CMD_CKS_EXIT; // [RULE15]
        end
      end
      sdc_pkg::PW_NORMAL: begin
        if (cke_prev_q && !bus.cke) begin // [RULE17]
          if (!bus.cs_n && code == sdc_pkg::CODE_REF && all_idle && !run_q) begin
            cmd = sdc_pkg::CMD_SREF_ENTER; // [RULE11]
          end else if (run_q) begin
            cmd = sdc_pkg::CMD_CKS_ENTER; // [RULE13]
          end else if (bus.cs_n || code == sdc_pkg::CODE_NOP) begin
            cmd = sdc_pkg::CMD_PD_ENTER; // [RULE14]
          end else if (!all_idle) begin
            cmd = sdc_pkg::CMD_CKS_ENTER; // [RULE13]
          end else begin
            cmd = sdc_pkg::CMD_PD_ENTER;
          end
        end else if (cke_prev_q) begin
          if (bus.cs_n) begin
            cmd = sdc_pkg::CMD_DESEL; // [RULE9]
          end else begin
            unique case (code) // [RULE1]
              sdc_pkg::CODE_ACT: if (!sel_active) cmd = sdc_pkg::CMD_ACT; // [RULE2]
              sdc_pkg::CODE_PRE: begin
                cmd = bus.addr[sdc_pkg::AP_BIT] ? sdc_pkg::CMD_PREALL : sdc_pkg::CMD_PRE; // [RULE3]
              end
              sdc_pkg::CODE_WR: if (sel_active) cmd = sdc_pkg::CMD_WR; // [RULE4]
              sdc_pkg::CODE_RD: if (sel_active) cmd = sdc_pkg::CMD_RD; // [RULE5]
              sdc_pkg::CODE_MRS: if (all_idle) cmd = sdc_pkg::CMD_MRS; // [RULE6]
              sdc_pkg::CODE_NOP: cmd = sdc_pkg::CMD_NOP; // [RULE7]
              sdc_pkg::CODE_BST: if (!all_idle) cmd = sdc_pkg::CMD_BST; // [RULE8]
              sdc_pkg::CODE_REF: if (bus.cke && all_idle) cmd = sdc_pkg::CMD_REF; // [RULE10]
            endcase
          end
        end
      end
    endcase
  end

  // burst beat sequencing; a new column command cuts the running burst short
  assign start = (cmd == sdc_pkg::CMD_WR) || (cmd == sdc_pkg::CMD_RD);
  assign stop = (cmd == sdc_pkg::CMD_BST) || (cmd == sdc_pkg::CMD_PREALL) ||
                (cmd == sdc_pkg::CMD_PRE && bus.ba == bank_q); // [RULE8]
  // deselect and nop fall through here and leave the burst running [RULE22]
  assign beat = start || (run_q && pwr_q == sdc_pkg::PW_NORMAL && cke_prev_q && !stop);
  assign mask = sdc_pkg::burst_mask(mode_q[2:0]);
  assign beat_wr = start ? (cmd == sdc_pkg::CMD_WR) : wr_q;
  assign beat_bank = start ? bus.ba : bank_q;
  assign beat_col = start ? sdc_pkg::col_of(bus.addr) : col_q; // [RULE20]
  assign ap_eff = start ? bus.addr[sdc_pkg::AP_BIT] : ap_q; // [RULE20]
  assign last = start ? (mask == 3'h0) : (left_q == 3'h1);
  assign col_nx = (beat_col & ~{9'h000, mask}) | ((beat_col + 12'h001) & {9'h000, mask});

  always_comb begin
    act_set = '0;
    act_clr = '0;
    if (cmd == sdc_pkg::CMD_ACT) begin
      act_set = sdc_pkg::bank_onehot(bus.ba); // [RULE2]
    end
    if (cmd == sdc_pkg::CMD_PRE) begin
      act_clr = sdc_pkg::bank_onehot(bus.ba); // [RULE3]
    end else if (cmd == sdc_pkg::CMD_PREALL) begin
      act_clr = 4'hF; // [RULE3]
    end else if (beat && last && ap_eff) begin
      act_clr = sdc_pkg::bank_onehot(beat_bank); // [RULE4] [RULE5]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cke_prev_q <= 1'b1;
    end else begin
      cke_prev_q <= bus.cke; // [RULE17]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pwr_q <= sdc_pkg::PW_NORMAL;
    end else begin
      unique case (cmd)
        sdc_pkg::CMD_SREF_ENTER: pwr_q <= sdc_pkg::PW_SELF;
        sdc_pkg::CMD_PD_ENTER: pwr_q <= sdc_pkg::PW_PDOWN;
        sdc_pkg::CMD_CKS_ENTER: pwr_q <= sdc_pkg::PW_SUSP;
        sdc_pkg::CMD_SREF_EXIT, sdc_pkg::CMD_PD_EXIT, sdc_pkg::CMD_CKS_EXIT: pwr_q <= sdc_pkg::PW_NORMAL;
        default: pwr_q <= pwr_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      bank_act_q <= '0;
    end else begin
      bank_act_q <= (bank_act_q | act_set) & ~act_clr;
    end
  end

  // row store only feeds the user-side address; no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (cmd == sdc_pkg::CMD_ACT) begin
      row_q[bus.ba] <= bus.addr;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mode_q <= sdc_pkg::MODE_RST;
      cmd_q <= sdc_pkg::CMD_NONE;
      refresh_q <= 1'b0;
    end else begin
      if (cmd == sdc_pkg::CMD_MRS) begin
        mode_q <= bus.addr; // [RULE6]
      end
      cmd_q <= cmd;
      refresh_q <= (cmd == sdc_pkg::CMD_REF); // [RULE10]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      run_q <= 1'b0;
      left_q <= 3'h0;
      wr_q <= 1'b0;
      ap_q <= 1'b0;
      bank_q <= '0;
      col_q <= '0;
    end else if (start) begin
      run_q <= (mask != 3'h0);
      left_q <= mask;
      wr_q <= beat_wr;
      ap_q <= ap_eff;
      bank_q <= beat_bank;
      col_q <= col_nx;
    end else if (beat) begin
      run_q <= !last;
      left_q <= left_q - 3'h1;
      col_q <= col_nx;
    end else if (stop) begin
      run_q <= 1'b0; // [RULE8]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_valid_q <= 1'b0;
      wr_bank_q <= '0;
      wr_row_q <= '0;
      wr_col_q <= '0;
      wr_data_q <= '0;
      wr_be_q <= '0;
    end else begin
      wr_valid_q <= beat && beat_wr;
      if (beat && beat_wr) begin
        wr_bank_q <= beat_bank;
        wr_row_q <= row_q[beat_bank];
        wr_col_q <= beat_col;
        wr_data_q <= bus.dq;
        wr_be_q <= ~bus.dqm; // [RULE19]
      end
    end
  end

  // two-stage read: request to the user, then the returned word onto the bus
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_req_q <= 1'b0;
      rd_bank_q <= '0;
      rd_row_q <= '0;
      rd_col_q <= '0;
      rd_mask_q <= sdc_pkg::DQM_RST;
      dq_o_q <= '0;
      dq_oe_n_q <= 4'hF;
    end else begin
      rd_req_q <= beat && !beat_wr;
      if (beat && !beat_wr) begin
        rd_bank_q <= beat_bank;
        rd_row_q <= row_q[beat_bank];
        rd_col_q <= beat_col;
        rd_mask_q <= bus.dqm;
      end
      dq_o_q <= i_rd_data;
      dq_oe_n_q <= rd_req_q ? rd_mask_q : 4'hF; // [RULE19]
    end
  end

  assign bus.d_dq_o = dq_o_q;
  assign bus.d_dq_oe_n = dq_oe_n_q;
  assign o_cmd = cmd_q;
  assign o_pwr = pwr_q;
  assign o_bank_active = bank_act_q;
  assign o_mode = mode_q;
  assign o_refresh = refresh_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr_bank = wr_bank_q;
  assign o_wr_row = wr_row_q;
  assign o_wr_col = wr_col_q;
  assign o_wr_data = wr_data_q;
  assign o_wr_be = wr_be_q;
  assign o_rd_req = rd_req_q;
  assign o_rd_bank = rd_bank_q;
  assign o_rd_row = rd_row_q;
  assign o_rd_col = rd_col_q;
endmodule
`default_nettype wire

// ---- sdc_host.sv ----
// controller end: queues bus-cycle words in a fifo and plays one per clock onto the pins
// assumes the user sequences commands legally; the fifo lets the user stall the bus with i_hold
`default_nettype none
module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;

  // depth must be a power of two for the wrap bit to work
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rp_q[AW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (i_valid && !full) begin
      mem[wp_q[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (i_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (i_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

module sdc_host (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  sdc_if.host bus,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic i_cke,
  input wire sdc_pkg::sdc_op_t i_op,
  input wire logic [sdc_pkg::BA_W-1:0] i_ba,
  input wire logic [sdc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_auto_precharge_flag,
  input wire logic [sdc_pkg::LANES-1:0] i_dqm,
  input wire logic i_drive,
  input wire logic [sdc_pkg::DQ_W-1:0] i_data,
  input wire logic i_capture,
  input wire logic i_hold,
  output logic o_rd_valid,
  output logic [sdc_pkg::DQ_W-1:0] o_rd_data
);
  sdc_pkg::sdc_word_t in_w;
  sdc_pkg::sdc_word_t out_w;
  logic out_valid;
  logic pop;
  logic cke_q;
  sdc_pkg::sdc_pins_t pins_q;
  logic [sdc_pkg::BA_W-1:0] ba_q;
  logic [sdc_pkg::ADDR_W-1:0] addr_q;
  logic [sdc_pkg::LANES-1:0] dqm_q;
  logic [sdc_pkg::DQ_W-1:0] dq_o_q;
  logic dq_oe_n_q;
  logic cap_q;
  logic rd_valid_q;
  logic [sdc_pkg::DQ_W-1:0] rd_data_q;
  logic a10;

  assign in_w = '{cke: i_cke, op: i_op, ba: i_ba, addr: i_addr, auto_precharge_flag: i_auto_precharge_flag,
                  dqm: i_dqm, drive: i_drive, data: i_data, capture: i_capture};
  assign pop = out_valid && !i_hold;

  sdc_fifo #(.WIDTH($bits(sdc_pkg::sdc_word_t)), .DEPTH(sdc_pkg::FIFO_DEPTH)) sdc_fifo_inst (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_valid(i_valid),
    .o_ready(o_ready),
    .i_data(in_w),
    .o_valid(out_valid),
    .i_ready(pop),
    .o_data(out_w)
  );

  // a10 picks one bank or all on precharge and carries auto precharge on column commands
  always_comb begin
    unique case (out_w.op)
      sdc_pkg::OP_PRE: a10 = 1'b0; // [RULE3]
      sdc_pkg::OP_PREALL: a10 = 1'b1; // [RULE3]
      sdc_pkg::OP_WR, sdc_pkg::OP_RD: a10 = out_w.auto_precharge_flag; // [RULE4] [RULE5] [RULE20]
      default: a10 = out_w.addr[sdc_pkg::AP_BIT];
    endcase
  end

  // an empty queue plays nop with the enable held, so power down or self refresh is not left by accident
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cke_q <= 1'b1;
      pins_q <= sdc_pkg::op_pins(sdc_pkg::OP_NOP);
      ba_q <= '0;
      addr_q <= '0;
      dqm_q <= sdc_pkg::DQM_RST;
      dq_o_q <= '0;
      dq_oe_n_q <= 1'b1;
      cap_q <= 1'b0;
    end else if (pop) begin
      cke_q <= out_w.cke;
      pins_q <= sdc_pkg::op_pins(out_w.op); // [RULE1] [RULE2] [RULE6] [RULE8] [RULE10] [RULE11]
      ba_q <= out_w.ba; // [RULE21]
      addr_q <= {out_w.addr[12:11], a10, out_w.addr[9:0]};
      dqm_q <= out_w.dqm; // [RULE19]
      dq_o_q <= out_w.data;
      dq_oe_n_q <= !out_w.drive;
      cap_q <= out_w.capture;
    end else begin
      pins_q <= sdc_pkg::op_pins(sdc_pkg::OP_NOP); // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16]
      dqm_q <= sdc_pkg::DQM_RST;
      dq_oe_n_q <= 1'b1;
      cap_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= cap_q;
      if (cap_q) begin
        rd_data_q <= bus.dq;
      end
    end
  end

  assign bus.cke = cke_q;
  assign bus.cs_n = pins_q.cs_n;
  assign bus.ras_n = pins_q.ras_n;
  assign bus.cas_n = pins_q.cas_n;
  assign bus.we_n = pins_q.we_n;
  assign bus.ba = ba_q;
  assign bus.addr = addr_q;
  assign bus.dqm = dqm_q;
  assign bus.h_dq_o = dq_o_q;
  assign bus.h_dq_oe_n = dq_oe_n_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
endmodule
`default_nettype wire

// ---- sdc_chk.sv ----
// assertions on the pin bundle between the controller end and the memory end
// assumes one clock domain; instantiated beside the interface, no bind
`default_nettype none
module sdc_chk (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [3:0] dqm,
  input wire logic [31:0] h_dq_o,
  input wire logic h_dq_oe_n,
  input wire logic [31:0] d_dq_o,
  input wire logic [3:0] d_dq_oe_n,
  input wire logic [31:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic rd_c;
  logic [3:0] age_q;
  assign rd_c = cke && !cs_n && {ras_n, cas_n, we_n} == sdc_pkg::CODE_RD;
  // saturates so a long idle never wraps back into the read window
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || rd_c) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end
  idle_nop_a: assert property ($fell(i_srst) |-> {cke, cs_n, ras_n, cas_n, we_n, dqm, h_dq_oe_n} == 10'h2FF)
    else $error("pins not idle after reset");
  no_fight_a: assert property (!h_dq_oe_n |-> &d_dq_oe_n)
    else $error("both ends drive data");
  rd_mask_a: assert property (d_dq_oe_n != 4'hF |-> d_dq_oe_n == $past(dqm, 2))
    else $error("read lanes disagree with mask");
  rd_window_a: assert property (d_dq_oe_n != 4'hF |-> age_q <= 4'h9)
    else $error("read data without a read");
  wr_bus_a: assert property (!h_dq_oe_n |-> dq == h_dq_o)
    else $error("write data lost on bus");
  lane_low_a: assert property (!d_dq_oe_n[0] |-> dq[7:0] == d_dq_o[7:0])
    else $error("lane 0 not from memory");
  lane_high_a: assert property (!d_dq_oe_n[3] |-> dq[31:24] == d_dq_o[31:24])
    else $error("lane 3 not from memory");
  bus_float_a: assert property (h_dq_oe_n && &d_dq_oe_n |-> dq == 32'h0)
    else $error("undriven bus not zero");
  cover property (rd_c);
  cover property (!h_dq_oe_n);
  cover property ($fell(cke));
endmodule
`default_nettype wire

// ---- sdc_tb.sv ----
// bench: both ends joined by the interface, user sides driven and judged here
// assumes one 250 MHz clock; memory read data is a fixed pattern
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, vld = 0, hold = 0, rdy, rvld, wv, rq, rf;
  logic [31:0] rdat, wdat, rin = 32'hCAFE0123;
  logic [11:0] wcol, rcol;
  logic [3:0] act, wbe;
  logic [1:0] wbk, rbk;
  logic [12:0] mode, wrow, rrow;
  logic [31:0] wlog [8], clog [8];
  sdc_pkg::sdc_word_t w = '0;
  sdc_pkg::sdc_cmd_t cmd;
  sdc_pkg::sdc_pwr_t pwr;
  int n_fail = 0, comparisons = 0, cyc = 0, nw = 0, nr = 0, nc = 0;
  always #2 clk = ~clk;
  sdc_if bus_if ();
  sdc_host sdc_host_inst (.i_ref_clk(clk), .i_srst(rst), .bus(bus_if.host), .i_valid(vld), .o_ready(rdy),
    .i_cke(w.cke), .i_op(w.op), .i_ba(w.ba), .i_addr(w.addr), .i_auto_precharge_flag(w.auto_precharge_flag),
    .i_dqm(w.dqm), .i_drive(w.drive), .i_data(w.data), .i_capture(w.capture), .i_hold(hold),
    .o_rd_valid(rvld), .o_rd_data(rdat));
  sdc_dev sdc_dev_inst (.i_ref_clk(clk), .i_srst(rst), .bus(bus_if.dev), .i_rd_data(rin), .o_cmd(cmd),
    .o_pwr(pwr), .o_bank_active(act), .o_mode(mode), .o_refresh(rf), .o_wr_valid(wv), .o_wr_bank(wbk),
    .o_wr_row(wrow), .o_wr_col(wcol), .o_wr_data(wdat), .o_wr_be(wbe), .o_rd_req(rq), .o_rd_bank(rbk),
    .o_rd_row(rrow), .o_rd_col(rcol));
  sdc_chk sdc_chk_inst (.i_ref_clk(clk), .i_srst(rst), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .dqm(bus_if.dqm), .h_dq_o(bus_if.h_dq_o),
    .h_dq_oe_n(bus_if.h_dq_oe_n), .d_dq_o(bus_if.d_dq_o), .d_dq_oe_n(bus_if.d_dq_oe_n), .dq(bus_if.dq));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // outputs are sampled at the edge, before that edge's updates land
  always @(posedge clk) begin
    cyc++;
    if (wv) wlog[nw++] = {wbe, wcol[3:0], 8'h00, wdat[31:16]};
    if (rq) nr++;
    if (rvld) clog[nc++] = rdat;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic sdc_pkg::sdc_word_t mk(input logic k, input sdc_pkg::sdc_op_t op, input logic [1:0] b,
    input logic [12:0] a, input logic [3:0] m = 4'h0, input logic dr = 1'h0, input logic [31:0] d = 32'h0,
    input logic c = 1'h0);
    return '{k, op, b, a, a[10], m, dr, d, c};
  endfunction
  // request held until the edge that sees ready high
  task automatic push(input sdc_pkg::sdc_word_t x);
    w = x;
    vld = 1;
    while (!rdy) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask
  task automatic idle(input int n);
    vld = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // poll a level or pulse; 0 cmd, 1 power, 2 banks, 3 refresh
  task automatic await(input int s, input logic [31:0] e);
    logic [31:0] g;
    for (int i = 0; i < 24; i++) begin
      g = s == 0 ? 32'(cmd) : s == 1 ? 32'(pwr) : s == 2 ? 32'(act) : 32'(rf);
      if (g === e) break;
      @(posedge clk) #1;
    end
    chk(g, e);
  endtask
  task automatic t_fifo;
    hold = 1;
    repeat (8) push(mk(1, sdc_pkg::OP_NOP, 0, 0));
    vld = 0;
    chk(rdy, 0);
    hold = 0;
    idle(10);
    chk(rdy, 1);
    $display("fifo test done");
  endtask
  task automatic t_bank;
    push(mk(1, sdc_pkg::OP_MRS, 0, 13'h0002));
    push(mk(1, sdc_pkg::OP_ACT, 2, 13'h0123));
    await(2, 4);
    chk(mode, 2);
    push(mk(1, sdc_pkg::OP_ACT, 2, 13'h0055));
    await(0, sdc_pkg::CMD_NONE);
    push(mk(1, sdc_pkg::OP_PRE, 1, 0));
    await(0, sdc_pkg::CMD_PRE);
    chk(act, 4);
    $display("bank test done");
  endtask
  task automatic t_write;
    for (int i = 0; i < 4; i++) push(mk(1, i ? sdc_pkg::OP_NOP : sdc_pkg::OP_WR, 2, 5, i == 2 ? 4'h3 : 4'h0, 1,
      32'hA0000000 + (i << 16)));
    idle(8);
    chk(nw, 4);
    for (int i = 0; i < 4; i++) begin
      chk(wlog[i], {i == 2 ? 4'hC : 4'hF, 4'(4 + (i + 1) % 4), 8'h00, 16'(16'hA000 + i)});
    end
    chk({wbk, wrow}, {2'h2, 13'h0123});
    $display("write test done");
  endtask
  task automatic t_read;
    push(mk(1, sdc_pkg::OP_RD, 2, 13'h0400));
    push(mk(1, sdc_pkg::OP_NOP, 2, 0, 4'h1));
    repeat (4) push(mk(1, sdc_pkg::OP_NOP, 2, 0, 4'h0, 0, 0, 1));
    idle(4);
    chk(nc, 4);
    for (int i = 0; i < 4; i++) chk(clog[i], i == 1 ? 32'hCAFE0100 : 32'hCAFE0123);
    chk(act, 0);
    chk({rbk, rrow, rcol}, {2'h2, 13'h0123, 12'h003});
    $display("read test done");
  endtask
  task automatic t_bst;
    nr = 0;
    push(mk(1, sdc_pkg::OP_ACT, 0, 13'h0011));
    push(mk(1, sdc_pkg::OP_RD, 0, 0));
    push(mk(1, sdc_pkg::OP_BST, 0, 0));
    idle(8);
    chk(nr, 1);
    nr = 0;
    push(mk(1, sdc_pkg::OP_RD, 0, 0));
    push(mk(1, sdc_pkg::OP_DESEL, 0, 0));
    push(mk(1, sdc_pkg::OP_NOP, 0, 0));
    idle(8);
    chk(nr, 4);
    $display("stop test done");
  endtask
  task automatic t_power;
    push(mk(0, sdc_pkg::OP_BST, 0, 0));
    await(1, sdc_pkg::PW_SUSP);
    push(mk(1, sdc_pkg::OP_NOP, 0, 0));
    await(1, sdc_pkg::PW_NORMAL);
    push(mk(1, sdc_pkg::OP_PREALL, 3, 13'h0400));
    await(2, 0);
    push(mk(0, sdc_pkg::OP_NOP, 0, 0));
    await(1, sdc_pkg::PW_PDOWN);
    push(mk(1, sdc_pkg::OP_NOP, 0, 0));
    await(1, sdc_pkg::PW_NORMAL);
    push(mk(1, sdc_pkg::OP_REF, 0, 0));
    await(3, 1);
    push(mk(0, sdc_pkg::OP_REF, 0, 0));
    await(1, sdc_pkg::PW_SELF);
    push(mk(1, sdc_pkg::OP_DESEL, 0, 0));
    await(1, sdc_pkg::PW_NORMAL);
    $display("power test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    chk(pwr, sdc_pkg::PW_NORMAL);
    chk(act, 0);
    chk(cmd, sdc_pkg::CMD_NONE);
    t_fifo();
    t_bank();
    t_write();
    t_read();
    t_bst();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire
